// ### verilog/rsc_map.svh
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH
// APB register offsets
`define RSC_OFF_CTRL     12'h000
`define RSC_OFF_CFG      12'h004
`define RSC_OFF_STATUS   12'h008
`define RSC_OFF_CAUSE    12'h00c
// Control fields
`define RSC_CTRL_HALT    0
`define RSC_CTRL_HOLD    1
`define RSC_CTRL_XHOLD   2
`define RSC_CTRL_XSEL    3
`define RSC_CTRL_XRUN    4
// Config fields
`define RSC_CFG_POR_LSB  0
`define RSC_CFG_LVD_LSB  3
`define RSC_CFG_LVD_EN   6
`define RSC_CFG_LVL_A    7
`define RSC_CFG_LVL_B    8
// Reset values
`define RSC_CTRL_RST     5'h00
`define RSC_CFG_RST      9'h000
// Timing: oscillator settle time in ns and cycles at 25 MHz
`define RSC_CLK_NS       40
`define RSC_SETTLE_NS    2000
`define RSC_SETTLE_CYC   ((`RSC_SETTLE_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_RESET_CYC    16
`endif

// ### verilog/rsc_pkg.sv
package rsc_pkg;
    typedef enum logic [3:0] {
        RSC_RUN   = 4'b0001,
        RSC_HALT  = 4'b0010,
        RSC_HOLD  = 4'b0100,
        RSC_XHOLD = 4'b1000
    } rsc_state_t;
    typedef enum logic [1:0] {
        RSC_CAUSE_NONE = 2'h0,
        RSC_CAUSE_IRQ  = 2'h1,
        RSC_CAUSE_RST  = 2'h2
    } rsc_cause_t;
endpackage

// ### verilog/rsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= '0;
            q    <= '0;
        end else begin
            s1_r <= d;
            q    <= s1_r;
        end
    end
endmodule
`default_nettype wire

// ### verilog/rsc_ctrl.sv
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.svh"
module rsc_ctrl #(
    parameter int SETTLE_CYC = `RSC_SETTLE_CYC,
    parameter int RESET_CYC  = `RSC_RESET_CYC
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         power_good,
    input  wire logic         brownout_trip,
    input  wire logic         reset_pin_n,
    input  wire logic         wdt_reset,
    input  wire logic         port7_pin0,
    input  wire logic         ext_irq_b,
    input  wire logic         ext_irq_c,
    input  wire logic         ext_irq_e,
    input  wire logic [7:0]   port0_irq,
    input  wire logic         base_timer_irq,
    input  wire logic         irq_pending,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    output logic              sys_reset,
    output logic              core_run,
    output logic              periph_run,
    output logic              base_timer_run,
    output logic              ceramic_osc_en,
    output logic              rc_osc_en,
    output logic              crystal_osc_en,
    output logic [2:0]        por_level,
    output logic [2:0]        brownout_level,
    output logic              brownout_en,
    output logic              wake_irq
);
    import rsc_pkg::*;

    initial begin
        if (SETTLE_CYC < 1 || SETTLE_CYC > 65535 || RESET_CYC < 1 || RESET_CYC > 65535) begin
            $error("rsc_ctrl: counts out of range");
        end
    end

    //------------------------------------------------------------
    // Input synchronisers
    //------------------------------------------------------------
    logic [5:0] raw_in;
    logic [5:0] sync_in;
    logic [7:0] p0_sync;
    assign raw_in = {port7_pin0, ext_irq_b, ext_irq_c, ext_irq_e, reset_pin_n, brownout_trip};
    rsc_sync #(.W(6)) u_sync_pin (
        .clk (clk),
        .rst (rst),
        .d   (raw_in),
        .q   (sync_in)
    );
    rsc_sync #(.W(8)) u_sync_p0 (
        .clk (clk),
        .rst (rst),
        .d   (port0_irq),
        .q   (p0_sync)
    );
    logic irq_a_s, irq_b_s, irq_c_s, irq_e_s, pin_low_s, bo_s;
    assign {irq_a_s, irq_b_s, irq_c_s, irq_e_s} = sync_in[5:2];
    assign pin_low_s = ~sync_in[1];
    assign bo_s      = sync_in[0];

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    logic [4:0]  ctrl_r;
    logic [8:0]  cfg_r;
    logic [2:0]  por_level_r;
    logic        por_done_r;
    rsc_state_t  state_r;
    rsc_cause_t  cause_r;
    logic [15:0] rst_cnt_r;
    logic [15:0] settle_cnt_r;
    logic        settling_r;
    logic        xtal_kept_r;
    logic        xtal_run_r;

    logic wr_en;
    logic rd_en;
    assign wr_en = psel && penable && pwrite;
    // Read data is registered in the setup cycle, so it stands at the completion edge
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;

    // Reset sources: power-up, enabled brownout, pin, watchdog
    logic reset_src;
    assign reset_src = !por_done_r || (cfg_r[`RSC_CFG_LVD_EN] && bo_s) || pin_low_s || wdt_reset;

    //------------------------------------------------------------
    // Power-on reset
    //------------------------------------------------------------
    // Armed only by rst (the power-up event); brownout never rearms it
    always_ff @(posedge clk) begin
        if (rst) begin
            por_done_r <= 1'b0;
        end else if (power_good) begin
            por_done_r <= 1'b1;
        end
    end

    // Release level is latched once, when power-up finishes
    always_ff @(posedge clk) begin
        if (rst) begin
            por_level_r <= 3'h0;
        end else if (!por_done_r) begin
            por_level_r <= cfg_r[`RSC_CFG_POR_LSB +: 3];
        end
    end

    //------------------------------------------------------------
    // System reset stretch
    //------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rst_cnt_r <= 16'(RESET_CYC);
        end else if (reset_src) begin
            rst_cnt_r <= 16'(RESET_CYC);
        end else if (rst_cnt_r != 16'h0000) begin
            rst_cnt_r <= rst_cnt_r - 16'h0001;
        end
    end
    assign sys_reset = rst_cnt_r != 16'h0000;

    //------------------------------------------------------------
    // Configuration and control registers
    //------------------------------------------------------------
    // Config survives system resets so brownout stays armed
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_r <= `RSC_CFG_RST;
        end else if (wr_en && paddr == `RSC_OFF_CFG) begin
            cfg_r <= pwdata[8:0];
        end
    end

    // Wake sources; irq a/b only in level-detect mode
    logic wake_stop;
    logic wake_xhold;
    assign wake_stop  = (cfg_r[`RSC_CFG_LVL_A] && irq_a_s) || (cfg_r[`RSC_CFG_LVL_B] && irq_b_s)
                        || irq_c_s || irq_e_s || (|p0_sync);
    assign wake_xhold = wake_stop || base_timer_irq;

    always_ff @(posedge clk) begin
        if (rst || sys_reset) begin
            ctrl_r <= `RSC_CTRL_RST;
        end else if (wr_en && paddr == `RSC_OFF_CTRL) begin
            ctrl_r <= pwdata[4:0];
        end else begin
            // Mode request bits self-clear on the cycle after the write, whether or not the state is taken
            ctrl_r[2:0] <= 3'h0;
        end
    end

    //------------------------------------------------------------
    // Standby state machine
    //------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || sys_reset) begin
            state_r <= RSC_RUN;
        end else begin
            case (state_r)
                RSC_RUN: begin
                    if (settling_r) begin
                        state_r <= RSC_RUN;
                    end else if (ctrl_r[`RSC_CTRL_HOLD]) begin
                        state_r <= RSC_HOLD;
                    end else if (ctrl_r[`RSC_CTRL_XHOLD] && ctrl_r[`RSC_CTRL_XSEL]) begin
                        state_r <= RSC_XHOLD;
                    end else if (ctrl_r[`RSC_CTRL_HALT]) begin
                        state_r <= RSC_HALT;
                    end
                end
                RSC_HALT: begin
                    if (irq_pending || wake_xhold) begin
                        state_r <= RSC_RUN;
                    end
                end
                RSC_HOLD: begin
                    if (wake_stop) begin
                        state_r <= RSC_RUN;
                    end
                end
                RSC_XHOLD: begin
                    if (wake_xhold) begin
                        state_r <= RSC_RUN;
                    end
                end
                default: begin
                    state_r <= RSC_RUN;
                end
            endcase
        end
    end

    // Clock settle after leaving a stop state
    logic stop_exit;
    assign stop_exit = (state_r == RSC_HOLD && wake_stop) || (state_r == RSC_XHOLD && wake_xhold);
    always_ff @(posedge clk) begin
        if (rst || sys_reset) begin
            settling_r   <= 1'b1;
            settle_cnt_r <= 16'(SETTLE_CYC);
        end else if (stop_exit) begin
            settling_r   <= 1'b1;
            settle_cnt_r <= 16'(SETTLE_CYC);
        end else if (settle_cnt_r != 16'h0000) begin
            settle_cnt_r <= settle_cnt_r - 16'h0001;
        end else begin
            settling_r <= 1'b0;
        end
    end

    // Crystal state at entry is frozen for the crystal stop
    always_ff @(posedge clk) begin
        if (rst || sys_reset) begin
            xtal_run_r  <= 1'b0;
            xtal_kept_r <= 1'b0;
        end else begin
            if (wr_en && paddr == `RSC_OFF_CTRL) begin
                xtal_run_r <= pwdata[`RSC_CTRL_XRUN];
            end
            if (state_r == RSC_RUN) begin
                xtal_kept_r <= xtal_run_r;
            end
        end
    end

    // Wake cause: set wins, cleared by write of CAUSE
    always_ff @(posedge clk) begin
        if (rst) begin
            cause_r <= RSC_CAUSE_NONE;
        end else if (reset_src && state_r != RSC_RUN) begin
            cause_r <= RSC_CAUSE_RST;
        end else if (state_r != RSC_RUN && !sys_reset && (irq_pending || wake_xhold)) begin
            cause_r <= RSC_CAUSE_IRQ;
        end else if (wr_en && paddr == `RSC_OFF_CAUSE) begin
            cause_r <= RSC_CAUSE_NONE;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    assign core_run       = !sys_reset && !settling_r && state_r == RSC_RUN;
    assign periph_run     = !sys_reset && (state_r == RSC_RUN || state_r == RSC_HALT);
    assign base_timer_run = periph_run || state_r == RSC_XHOLD;
    // Ceramic restarts after reset; halt keeps it as is
    assign ceramic_osc_en = !(state_r == RSC_HOLD || state_r == RSC_XHOLD);
    assign rc_osc_en      = ceramic_osc_en && !sys_reset;
    assign crystal_osc_en = !sys_reset && ((state_r == RSC_XHOLD) ? xtal_kept_r
                            : (state_r != RSC_HOLD && xtal_run_r));
    assign por_level      = por_level_r;
    assign brownout_level = cfg_r[`RSC_CFG_LVD_LSB +: 3];
    assign brownout_en    = cfg_r[`RSC_CFG_LVD_EN];
    assign wake_irq       = irq_a_s;
    assign pslverr        = 1'b0;

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr)
                `RSC_OFF_CTRL:   prdata <= {27'h0, xtal_run_r, ctrl_r[3:0]};
                `RSC_OFF_CFG:    prdata <= {23'h0, cfg_r};
                `RSC_OFF_STATUS: prdata <= {24'h0, sys_reset, settling_r, por_done_r, xtal_kept_r, state_r};
                `RSC_OFF_CAUSE:  prdata <= {30'h0, cause_r};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### test/rsc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_ctrl_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        reset_pin_n,
    input wire logic        wdt_reset,
    input wire logic        port7_pin0,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sys_reset,
    input wire logic        core_run,
    input wire logic        periph_run,
    input wire logic        base_timer_run,
    input wire logic        ceramic_osc_en,
    input wire logic        rc_osc_en,
    input wire logic        crystal_osc_en,
    input wire logic [2:0]  por_level,
    input wire logic [2:0]  brownout_level,
    input wire logic        brownout_en,
    input wire logic        wake_irq
);
    logic [31:0] pw_q;
    // Write data of the previous edge, so a config write can be tied to its result
    always_ff @(posedge clk) begin
        pw_q <= pwdata;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_apb_ready: assert property (pready && !pslverr) else $error("apb slave stalled or erred");
    a_cfg_write: assert property (psel && penable && pwrite && paddr == 12'h004 |=>
        $stable(por_level) && brownout_level == pw_q[5:3] && brownout_en == pw_q[6])
        else $error("config outputs not updated by write");
    a_rst_release: assert property ($fell(rst) |-> sys_reset) else $error("no reset after power-up");
    a_wdt_reset: assert property (wdt_reset |-> ##[1:3] sys_reset) else $error("watchdog gave no reset");
    a_pin_reset: assert property ($fell(reset_pin_n) |-> ##[1:4] sys_reset) else $error("pin gave no reset");
    a_reset_core: assert property (sys_reset |-> !core_run) else $error("core runs in reset");
    a_reset_xtal: assert property (sys_reset |-> !crystal_osc_en) else $error("crystal runs in reset");
    a_timer_link: assert property (periph_run |-> base_timer_run) else $error("base timer stopped");
    a_wake_sync: assert property ($rose(port7_pin0) |-> ##[1:4] wake_irq) else $error("wake not seen");
endmodule
`default_nettype wire

// ### test/rsc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_model (
    input  wire logic       clk,
    input  wire logic       fire,
    input  wire logic [2:0] fire_sel,
    output logic            reset_pin_n,
    output logic            port7_pin0,
    output logic            ext_irq_b,
    output logic            ext_irq_c,
    output logic            ext_irq_e,
    output logic [7:0]      port0_irq
);
    logic [3:0] hold_r = 4'h0;
    logic [2:0] sel_r = 3'h0;
    // Levels are held 8 cycles so level detection sees them through the synchronisers
    always @(posedge clk) begin
        if (fire) begin
            hold_r <= 4'h8;
            sel_r <= fire_sel;
        end else if (hold_r != 4'h0) begin
            hold_r <= hold_r - 4'h1;
        end
    end
    assign port7_pin0 = hold_r != 4'h0 && sel_r == 3'h0;
    assign ext_irq_b = hold_r != 4'h0 && sel_r == 3'h1;
    assign ext_irq_c = hold_r != 4'h0 && sel_r == 3'h2;
    assign ext_irq_e = hold_r != 4'h0 && sel_r == 3'h3;
    assign port0_irq = {7'h00, hold_r != 4'h0 && sel_r == 3'h4};
    // Pin has a pull-up, so it idles high
    assign reset_pin_n = !(hold_r != 4'h0 && sel_r == 3'h5);
endmodule
`default_nettype wire

// ### test/tb_reset_and_standby_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; $display("unexpected at %0t: %h vs %h", $time, (a), (e)); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 300) begin @(posedge clk); n++; end #1; end
module tb_reset_and_standby_control;
    import rsc_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, power_good = 1'b0, brownout_trip = 1'b0, wdt_reset = 1'b0;
    logic        base_timer_irq = 1'b0, irq_pending = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        fire = 1'b0;
    logic [2:0]  fire_sel = 3'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, seed = 32'h55d834b0, cfg_m;
    wire logic   reset_pin_n, port7_pin0, ext_irq_b, ext_irq_c, ext_irq_e, pready, pslverr, sys_reset;
    wire logic   core_run, periph_run, base_timer_run, ceramic_osc_en, rc_osc_en, crystal_osc_en;
    wire logic   brownout_en, wake_irq;
    wire logic [7:0]  port0_irq;
    wire logic [31:0] prdata;
    wire logic [2:0]  por_level, brownout_level;
    int          fails = 0, total_checks = 0, n;

    always #20 clk = ~clk;
    rsc_ctrl #(.SETTLE_CYC(2), .RESET_CYC(2)) u_rsc_ctrl (.*);
    rsc_pin_model u_rsc_pin_model (.*);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Prdata is loaded in the setup cycle and taken at the completion edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pin(input logic [2:0] s);
        @(posedge clk);
        fire <= 1'b1;
        fire_sel <= s;
        @(posedge clk);
        fire <= 1'b0;
    endtask
    task results;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        fails++;
        results;
    end
    //----------------------------------------
    // Scenarios
    //----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        power_good <= 1'b1;
        `WAITC(core_run === 1'b1)
        `CHK({sys_reset, ceramic_osc_en, crystal_osc_en}, 3'b010)
        apb(1'b0, 12'h004, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 12'h010, 32'h0);
        `CHK(rd, 32'h0)
        $display("reset test done");
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            cfg_m = (i == 4) ? 32'h1c0 : seed;
            apb(1'b1, 12'h004, cfg_m);
            apb(1'b0, 12'h004, 32'h0);
            `CHK(rd[8:0], cfg_m[8:0])
            `CHK({brownout_en, brownout_level, por_level}, {cfg_m[6:3], 3'h0})
        end
        $display("config test done");
        apb(1'b1, 12'h000, 32'h1);
        repeat (3) @(posedge clk);
        `CHK({core_run, periph_run, ceramic_osc_en}, 3'b011)
        irq_pending <= 1'b1;
        `WAITC(core_run === 1'b1)
        `CHK(core_run, 1'b1)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK(rd[1:0], 2'h1)
        irq_pending <= 1'b0;
        apb(1'b1, 12'h00c, 32'h0);
        apb(1'b1, 12'h000, 32'h0);
        $display("idle test done");
        for (int s = 0; s < 5; s++) begin
            apb(1'b1, 12'h000, 32'h2);
            repeat (3) @(posedge clk);
            `CHK({periph_run, ceramic_osc_en, rc_osc_en, crystal_osc_en}, 4'h0)
            pin(s[2:0]);
            `WAITC(core_run === 1'b1)
            `CHK({core_run, ceramic_osc_en}, 2'b11)
            apb(1'b1, 12'h000, 32'h0);
        end
        cfg_m = 32'h140;
        apb(1'b1, 12'h004, cfg_m);
        apb(1'b1, 12'h000, 32'h2);
        pin(3'h0);
        repeat (12) @(posedge clk);
        `CHK(core_run, 1'b0)
        pin(3'h2);
        `WAITC(core_run === 1'b1)
        apb(1'b1, 12'h000, 32'h0);
        $display("deep stop test done");
        apb(1'b1, 12'h000, 32'h4);
        repeat (3) @(posedge clk);
        `CHK(core_run, 1'b1)
        apb(1'b1, 12'h000, 32'h18);
        apb(1'b1, 12'h000, 32'h1c);
        repeat (3) @(posedge clk);
        `CHK({core_run, base_timer_run, ceramic_osc_en, rc_osc_en}, 4'b0100)
        `CHK(crystal_osc_en, 1'b1)
        base_timer_irq <= 1'b1;
        `WAITC(core_run === 1'b1)
        `CHK(core_run, 1'b1)
        base_timer_irq <= 1'b0;
        $display("crystal stop test done");
        for (int r = 0; r < 3; r++) begin
            apb(1'b1, 12'h000, 32'h1);
            if (r == 0) pin(3'h5);
            @(posedge clk);
            wdt_reset <= (r == 1);
            brownout_trip <= (r == 2);
            `WAITC(sys_reset === 1'b1)
            `CHK({sys_reset, crystal_osc_en}, 2'b10)
            @(posedge clk);
            wdt_reset <= 1'b0;
            brownout_trip <= 1'b0;
            `WAITC(core_run === 1'b1)
            `CHK({core_run, ceramic_osc_en, crystal_osc_en}, 3'b110)
            apb(1'b0, 12'h004, 32'h0);
            `CHK(rd[8:0], cfg_m[8:0])
        end
        $display("reset source test done");
        results;
    end
endmodule
bind rsc_ctrl rsc_ctrl_props u_rsc_ctrl_props (.clk, .rst, .reset_pin_n, .wdt_reset, .port7_pin0, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .sys_reset, .core_run, .periph_run, .base_timer_run,
    .ceramic_osc_en, .rc_osc_en, .crystal_osc_en, .por_level, .brownout_level, .brownout_en, .wake_irq);
`default_nettype wire
